// ---- pic_defines.svh ----
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PIC_OFF_CLKEN   8'h00
`define PIC_OFF_PRESC   8'h04
`define PIC_OFF_MODE    8'h08
`define PIC_OFF_START   8'h0C
`define PIC_OFF_STOP    8'h10
`define PIC_OFF_STATUS  8'h14
`define PIC_OFF_COUNT   8'h18
`define PIC_OFF_CAPT    8'h1C
`define PIC_OFF_IRQSTS  8'h20
`define PIC_OFF_IRQMSK  8'h24

// ****************************************
// Field positions
// ****************************************
`define PIC_CLKEN_GATE_BIT 0
`define PIC_MODE_MD_LSB    0
`define PIC_MODE_CIS_LSB   6
`define PIC_MODE_STS_LSB   8
`define PIC_TRIG_BIT       0
`define PIC_STAT_EN_BIT    0
`define PIC_STAT_OVF_BIT   1
`define PIC_IRQ_CAP_BIT    0
`define PIC_IRQ_START_BIT  1
`define PIC_IRQ_OVF_BIT    2

// ****************************************
// Codes and reset values
// ****************************************
`define PIC_MD_CAPTURE     4'h4
`define PIC_MD_CAPTURE_IRQ 4'h5
`define PIC_STS_SOFT       3'h0
`define PIC_STS_EDGE       3'h1
`define PIC_STS_BOTH       3'h2
`define PIC_RST_CLKEN      8'h00
`define PIC_RST_PRESC      4'h0
`define PIC_RST_MD         4'h0
`define PIC_RST_STS        3'h0
`define PIC_RST_IRQMSK     3'h0

`endif

// ---- pic_pkg.sv ----
package pic_pkg;

  // Valid edge choice of the capture input
  typedef enum logic [1:0]
  {
    PIC_EDGE_FALL,
    PIC_EDGE_RISE,
    PIC_EDGE_LOW,
    PIC_EDGE_HIGH
  } pic_edge_e;

  typedef logic [3:0] pic_mode_t;
  typedef logic [2:0] pic_trig_t;
  typedef logic [2:0] pic_irq_t;

endpackage

// ---- pic_prescaler.sv ----
`timescale 1ns/1ns
`default_nettype none

module pic_prescaler #(
  parameter int DIV_W = 15,
  parameter int SEL_W = 4
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             run_i,
  input  wire logic [SEL_W-1:0] sel_i,
  output logic                  tick_o
);

  logic [DIV_W-1:0] div_ff;
  logic             tick_ff;
  wire  [DIV_W-1:0] mask;
  wire              hit;

  // Select 0 gives a mask of zero, so the tick runs every cycle
  assign mask   = DIV_W'((32'h1 << sel_i) - 32'h1);
  assign hit    = (div_ff & mask) == mask;
  assign tick_o = tick_ff;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      div_ff  <= run_i ? div_ff + DIV_W'(1) : '0;
      tick_ff <= run_i & hit;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_direct_tick: assert property (
    run_i && sel_i == '0 |=> tick_o)
    else $error("undivided clock gave no tick");

endmodule

`default_nettype wire

// ---- pic_top.sv ----
// How it works
// - Start clears counter, counting begins
// - Valid edge copies count to capture
// - Capture clears count, raises capture interrupt
// - Stop trigger halts counting
// - Clock enable bit 0 gates unit
// - Capture mode on chosen valid edge
// - Operation clock selectable, undivided included
// - Capture mode with/without start interrupt
// - Edge field: fall, rise, both widths
// - Pin edge may start and capture
// - Start sets enable status, stop clears
`include "pic_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module pic_top #(
  parameter int CNT_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        capture_input_pin_i,
  output logic             irq_o
);

  import pic_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [7:0]       clken_ff;
  logic [3:0]       presc_ff;
  pic_mode_t        md_ff;
  pic_edge_e        cis_ff;
  pic_trig_t        sts_ff;
  logic             en_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] cap_ff;
  logic             ovf_pend_ff;
  logic             cap_ovf_ff;
  pic_irq_t         irq_sts_ff;
  pic_irq_t         irq_msk_ff;
  logic             pin_ff;
  logic             pready_ff;
  logic             pslverr_ff;
  logic [31:0]      prdata_ff;
  logic             irq_ff;

  // ****************************************
  // Register bus decode
  // ****************************************
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = addr == off;
  endfunction

  wire hit_clken  = reg_hit(paddr_i, `PIC_OFF_CLKEN);
  wire hit_presc  = reg_hit(paddr_i, `PIC_OFF_PRESC);
  wire hit_mode   = reg_hit(paddr_i, `PIC_OFF_MODE);
  wire hit_start  = reg_hit(paddr_i, `PIC_OFF_START);
  wire hit_stop   = reg_hit(paddr_i, `PIC_OFF_STOP);
  wire hit_status = reg_hit(paddr_i, `PIC_OFF_STATUS);
  wire hit_count  = reg_hit(paddr_i, `PIC_OFF_COUNT);
  wire hit_capt   = reg_hit(paddr_i, `PIC_OFF_CAPT);
  wire hit_irqsts = reg_hit(paddr_i, `PIC_OFF_IRQSTS);
  wire hit_irqmsk = reg_hit(paddr_i, `PIC_OFF_IRQMSK);

  wire addr_ok = hit_clken | hit_presc | hit_mode | hit_start | hit_stop
               | hit_status | hit_count | hit_capt | hit_irqsts | hit_irqmsk;

  // Answer is ready in the first access cycle; the flop drops after the handshake
  wire setup_go = psel_i & ~penable_i & ~pready_ff;
  wire wr_go    = psel_i & penable_i & pready_ff & pwrite_i & addr_ok;

  wire [31:0] rd_data =
      hit_clken  ? {24'h000000, clken_ff} :
      hit_presc  ? {28'h0000000, presc_ff} :
      hit_mode   ? {21'h000000, sts_ff, cis_ff, 2'h0, md_ff} :
      hit_status ? {30'h00000000, ovf_pend_ff, en_ff} :
      hit_count  ? {{(32-CNT_W){1'b0}}, cnt_ff} :
      hit_capt   ? {15'h0000, cap_ovf_ff, 16'(cap_ff)} :
      hit_irqsts ? {29'h00000000, irq_sts_ff} :
      hit_irqmsk ? {29'h00000000, irq_msk_ff} :
      32'h00000000;

  // ****************************************
  // Edge detection and trigger selection
  // ****************************************
  wire gate = clken_ff[`PIC_CLKEN_GATE_BIT];
  wire rise = capture_input_pin_i & ~pin_ff;
  wire fall = ~capture_input_pin_i & pin_ff;

  logic start_edge;
  logic cap_edge;

  // Width modes start on one edge and capture on the other
  always_comb
  begin
    start_edge = 1'b0;
    cap_edge   = 1'b0;
    case (cis_ff)
      PIC_EDGE_FALL:
      begin
        start_edge = fall;
        cap_edge   = fall;
      end
      PIC_EDGE_RISE:
      begin
        start_edge = rise;
        cap_edge   = rise;
      end
      PIC_EDGE_LOW:
      begin
        start_edge = fall;
        cap_edge   = rise;
      end
      PIC_EDGE_HIGH:
      begin
        start_edge = rise;
        cap_edge   = fall;
      end
      default:
      begin
        start_edge = 1'b0;
        cap_edge   = 1'b0;
      end
    endcase
  end

  wire cap_mode = (md_ff == `PIC_MD_CAPTURE) | (md_ff == `PIC_MD_CAPTURE_IRQ);
  wire pin_trig = (sts_ff == `PIC_STS_EDGE) | (sts_ff == `PIC_STS_BOTH);

  // Triggers are ignored while the unit clock is off, as if the unit were dark
  wire sw_start  = gate & wr_go & hit_start & pwdata_i[`PIC_TRIG_BIT];
  wire sw_stop   = gate & wr_go & hit_stop & pwdata_i[`PIC_TRIG_BIT];
  wire pin_start = gate & ~en_ff & cap_mode & pin_trig & start_edge;
  wire start_go  = sw_start | pin_start;
  wire cap_fire  = gate & en_ff & cap_mode & cap_edge & ~start_go & ~sw_stop;

  // ****************************************
  // Counter
  // ****************************************
  logic tick;

  pic_prescaler #(
    .DIV_W (15),
    .SEL_W (4)
  ) pic_prescaler_inst (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .run_i    (gate),
    .sel_i    (presc_ff),
    .tick_o   (tick)
  );

  wire cnt_step = gate & en_ff & tick & ~cap_fire & ~start_go & ~sw_stop;
  wire cnt_wrap = cnt_step & (&cnt_ff);

  wire [CNT_W-1:0] nxt_cnt =
      (start_go | cap_fire) ? '0 :
      cnt_step ? cnt_ff + CNT_W'(1) :
      cnt_ff;

  wire nxt_en       = sw_stop ? 1'b0 : (start_go ? 1'b1 : en_ff);
  wire nxt_ovf_pend = (start_go | cap_fire) ? 1'b0 : (cnt_wrap | ovf_pend_ff);

  // ****************************************
  // Interrupts
  // ****************************************
  wire start_irq = start_go & (md_ff == `PIC_MD_CAPTURE_IRQ);

  wire [2:0] irq_ev  = {cnt_wrap, start_irq, cap_fire};
  wire [2:0] irq_clr = (wr_go & hit_irqsts) ? pwdata_i[2:0] : 3'h0;

  // A new event in the clearing cycle survives the clear
  wire [2:0] nxt_irq_sts = (irq_sts_ff & ~irq_clr) | irq_ev;
  // Next mask too, so a mask write moves the line in the same cycle as the flop
  wire [2:0] nxt_irq_msk = (wr_go & hit_irqmsk) ? pwdata_i[2:0] : irq_msk_ff;
  wire       nxt_irq     = |(nxt_irq_sts & nxt_irq_msk);

  // ****************************************
  // Register bus flops
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end
    else
    begin
      pready_ff  <= setup_go;
      pslverr_ff <= setup_go & ~addr_ok;
      prdata_ff  <= (setup_go & ~pwrite_i) ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      clken_ff   <= `PIC_RST_CLKEN;
      presc_ff   <= `PIC_RST_PRESC;
      md_ff      <= `PIC_RST_MD;
      cis_ff     <= PIC_EDGE_FALL;
      sts_ff     <= `PIC_RST_STS;
      irq_msk_ff <= `PIC_RST_IRQMSK;
    end
    else if (wr_go)
    begin
      if (hit_clken)
        clken_ff <= pwdata_i[7:0];
      if (hit_presc)
        presc_ff <= pwdata_i[3:0];
      if (hit_mode)
      begin
        md_ff  <= pwdata_i[`PIC_MODE_MD_LSB +: 4];
        cis_ff <= pic_edge_e'(pwdata_i[`PIC_MODE_CIS_LSB +: 2]);
        sts_ff <= pwdata_i[`PIC_MODE_STS_LSB +: 3];
      end
      if (hit_irqmsk)
        irq_msk_ff <= pwdata_i[2:0];
    end
  end

  // ****************************************
  // Channel flops
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_ff      <= 1'b0;
      en_ff       <= 1'b0;
      cnt_ff      <= '0;
      ovf_pend_ff <= 1'b0;
      irq_sts_ff  <= 3'h0;
      irq_ff      <= 1'b0;
    end
    else
    begin
      pin_ff      <= capture_input_pin_i;
      en_ff       <= nxt_en;
      cnt_ff      <= nxt_cnt;
      ovf_pend_ff <= nxt_ovf_pend;
      irq_sts_ff  <= nxt_irq_sts;
      irq_ff      <= nxt_irq;
    end
  end

  // The first capture after a software start is a partial interval; software discards it
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cap_ff     <= '0;
      cap_ovf_ff <= 1'b0;
    end
    else if (cap_fire)
    begin
      cap_ff     <= cnt_ff;
      cap_ovf_ff <= ovf_pend_ff;
    end
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign irq_o     = irq_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_start_clears: assert property (
    sw_start |=> cnt_ff == '0 && en_ff)
    else $error("start did not clear and enable");

  a_capture_copy: assert property (
    cap_fire |=> cap_ff == $past(cnt_ff))
    else $error("capture value differs from count");

  a_capture_irq: assert property (
    cap_fire |=> cnt_ff == '0 && irq_sts_ff[`PIC_IRQ_CAP_BIT])
    else $error("capture did not clear count or flag");

  a_stop_halts: assert property (
    sw_stop |=> !en_ff ##1 ($stable(cnt_ff) || $past(start_go)))
    else $error("count moved after stop");

  a_gate_freeze: assert property (
    !gate |=> $stable(cnt_ff) && $stable(en_ff))
    else $error("gated unit changed state");

  a_rise_capture: assert property (
    gate && en_ff && md_ff == `PIC_MD_CAPTURE && cis_ff == PIC_EDGE_RISE
    && rise && !sw_stop && !start_go |=> irq_sts_ff[`PIC_IRQ_CAP_BIT] && cnt_ff == '0)
    else $error("rising edge missed");

  a_start_irq: assert property (
    start_go && md_ff == `PIC_MD_CAPTURE && !irq_sts_ff[`PIC_IRQ_START_BIT]
    |=> !irq_sts_ff[`PIC_IRQ_START_BIT])
    else $error("start interrupt in silent mode");

  a_low_width: assert property (
    gate && en_ff && cap_mode && cis_ff == PIC_EDGE_LOW && fall && !sw_stop
    |=> !irq_sts_ff[`PIC_IRQ_CAP_BIT] || $past(irq_sts_ff[`PIC_IRQ_CAP_BIT]))
    else $error("falling edge captured in low width mode");

  a_pin_start: assert property (
    pin_start && !sw_stop |=> en_ff && cnt_ff == '0)
    else $error("pin edge did not start");

  a_enable_flag: assert property (
    sw_stop |=> !en_ff ##1 (!en_ff || $past(start_go)))
    else $error("enable status wrong after stop");

  a_ovf_flag: assert property (
    cap_fire && ovf_pend_ff |=> cap_ovf_ff)
    else $error("overflow not kept with capture");

  a_irq_level: assert property (
    irq_o == |(irq_sts_ff & irq_msk_ff))
    else $error("interrupt level wrong");

endmodule

`default_nettype wire

// ---- pic_pulse_src.sv ----
`timescale 1ns/1ns
`default_nettype none

module pic_pulse_src (
  input  wire logic clk_i,
  output logic      pin_o
);
  // ****
  // Pulse source
  // ****
  // A synchronous source: the level only moves just after a rising edge
  initial pin_o = 1'b0;

  task automatic step(input logic lvl);
    @(posedge clk_i);
    pin_o <= lvl;
    // Room for the sampled edge to land in the registers
    repeat (3) @(posedge clk_i);
  endtask

  // Rising edges exactly per cycles apart, low for the first half
  task automatic train(input int cnt, input int per);
    repeat (cnt)
    begin
      repeat (per / 2) @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (per / 2) @(posedge clk_i);
      pin_o <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// ---- pic_top_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pic_defines.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module pic_top_bench;
  // ****
  // Wiring
  // ****
  logic        clk_i;
  logic        resetn_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        irq;
  logic [31:0] rd_v;
  logic        err_v;
  logic [31:0] keep_v;
  int          bad_count;
  int          checks_done;

  // Narrow counter so a wrap is reached in a few hundred cycles
  pic_top #(.CNT_W(8)) pic_top_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .capture_input_pin_i(pin), .irq_o(irq)
  );

  pic_pulse_src pic_pulse_src_inst (.clk_i(clk_i), .pin_o(pin));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ****
  // Bus and helpers
  // ****
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Ready and read data are taken at the rising edge that ends the access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge clk_i);
      n++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      bad_count++;
      report_and_stop();
    end
    else
    begin
      rd_v = prdata;
      err_v = pslverr;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    if (irq !== 1'b1)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask

  // Stop first: mode and prescaler are only changed on an idle channel
  task automatic cfg(input logic [31:0] presc, input logic [31:0] mode);
    wr(`PIC_OFF_STOP, 32'h1);
    wr(`PIC_OFF_PRESC, presc);
    wr(`PIC_OFF_MODE, mode);
    wr(`PIC_OFF_IRQSTS, 32'h7);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    logic [7:0] offs [8];
    offs = '{`PIC_OFF_CLKEN, `PIC_OFF_PRESC, `PIC_OFF_MODE, `PIC_OFF_STATUS,
             `PIC_OFF_COUNT, `PIC_OFF_CAPT, `PIC_OFF_IRQSTS, `PIC_OFF_IRQMSK};
    foreach (offs[i])
    begin
      rd(offs[i]);
      `CHK(rd_v, 32'h0)
    end
    rd(8'h30);
    `CHK({err_v, rd_v}, 33'h100000000)
    wr(`PIC_OFF_START, 32'h1);
    rd(`PIC_OFF_STATUS);
    `CHK(rd_v[0], 1'b0)
    $display("reset test done");
  endtask

  task automatic t_measure();
    cfg(32'h0, 32'h144);
    wr(`PIC_OFF_IRQMSK, 32'h1);
    wr(`PIC_OFF_START, 32'h1);
    rd(`PIC_OFF_STATUS);
    `CHK(rd_v[0], 1'b1)
    rd(`PIC_OFF_COUNT);
    keep_v = rd_v;
    rd(`PIC_OFF_COUNT);
    `CHK(rd_v > keep_v && keep_v < 32'h8, 1'b1)
    fork
      pic_pulse_src_inst.train(9, 40);
      for (int i = 0; i < 9; i++)
      begin
        wait_irq();
        rd(`PIC_OFF_CAPT);
        // The first value spans start to edge, not a full interval
        if (i > 0) `CHK(rd_v[15:0], 16'h0027)
        rd(`PIC_OFF_COUNT);
        `CHK(rd_v < 32'h10, 1'b1)
        wr(`PIC_OFF_IRQSTS, 32'h1);
        repeat (2) @(negedge clk_i);
        `CHK(irq, 1'b0)
      end
    join
    wr(`PIC_OFF_STOP, 32'h1);
    wr(`PIC_OFF_IRQMSK, 32'h0);
    rd(`PIC_OFF_STATUS);
    `CHK(rd_v[0], 1'b0)
    rd(`PIC_OFF_COUNT);
    keep_v = rd_v;
    wr(`PIC_OFF_CAPT, 32'hFF);
    rd(`PIC_OFF_COUNT);
    `CHK(rd_v, keep_v)
    rd(`PIC_OFF_CAPT);
    `CHK(rd_v[15:0], 16'h0027)
    $display("measure test done");
  endtask

  task automatic t_modes();
    for (int m = 4; m < 6; m++)
    begin
      cfg(32'h0, 32'(m));
      wr(`PIC_OFF_START, 32'h1);
      rd(`PIC_OFF_IRQSTS);
      `CHK(rd_v[1], (m == 5))
    end
    $display("mode test done");
  endtask

  task automatic t_edges();
    for (int e = 0; e < 4; e++)
    begin
      cfg(32'h0, 32'h4 | (e << 6));
      wr(`PIC_OFF_START, 32'h1);
      pic_pulse_src_inst.step(1'b1);
      rd(`PIC_OFF_IRQSTS);
      `CHK(rd_v[0], (e == 1 || e == 2))
      @(negedge clk_i);
      `CHK(irq, 1'b0)
      if (e == 1)
      begin
        wr(`PIC_OFF_IRQMSK, 32'h1);
        repeat (2) @(negedge clk_i);
        `CHK(irq, 1'b1)
        wr(`PIC_OFF_IRQMSK, 32'h0);
      end
      wr(`PIC_OFF_IRQSTS, 32'h1);
      pic_pulse_src_inst.step(1'b0);
      rd(`PIC_OFF_IRQSTS);
      `CHK(rd_v[0], (e == 0 || e == 3))
    end
    $display("edge test done");
  endtask

  task automatic t_pinstart();
    cfg(32'h0, 32'h144);
    pic_pulse_src_inst.step(1'b1);
    rd(`PIC_OFF_STATUS);
    `CHK(rd_v[0], 1'b1)
    pic_pulse_src_inst.step(1'b0);
    // Both-edge trigger in falling-edge mode: only the fall starts the channel
    cfg(32'h0, 32'h204);
    pic_pulse_src_inst.step(1'b1);
    rd(`PIC_OFF_STATUS);
    `CHK(rd_v[0], 1'b0)
    pic_pulse_src_inst.step(1'b0);
    rd(`PIC_OFF_STATUS);
    `CHK(rd_v[0], 1'b1)
    // A non-capture mode counts but ignores the valid edge
    cfg(32'h0, 32'h40);
    wr(`PIC_OFF_START, 32'h1);
    pic_pulse_src_inst.step(1'b1);
    rd(`PIC_OFF_IRQSTS);
    `CHK(rd_v[0], 1'b0)
    pic_pulse_src_inst.step(1'b0);
    $display("pin start test done");
  endtask

  task automatic t_presc();
    cfg(32'h1, 32'h144);
    wr(`PIC_OFF_START, 32'h1);
    pic_pulse_src_inst.train(3, 40);
    rd(`PIC_OFF_CAPT);
    // Tick phase against the edge may cost one count
    `CHK(rd_v[15:0] == 16'h0013 || rd_v[15:0] == 16'h0014, 1'b1)
    $display("prescale test done");
  endtask

  task automatic t_ovf();
    cfg(32'h0, 32'h144);
    wr(`PIC_OFF_START, 32'h1);
    pic_pulse_src_inst.train(2, 300);
    rd(`PIC_OFF_CAPT);
    `CHK(rd_v[16:0], 17'h1002B)
    rd(`PIC_OFF_IRQSTS);
    `CHK(rd_v[2], 1'b1)
    $display("overflow test done");
  endtask

  initial
  begin
    resetn_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    wr(`PIC_OFF_CLKEN, 32'h1);
    t_measure();
    t_modes();
    t_edges();
    t_pinstart();
    t_presc();
    t_ovf();
    report_and_stop();
  end
endmodule

`default_nettype wire
